// ### src/tmr_capture_compare.sv
// 16-bit timer with two capture/compare channels behind apb
`timescale 1ns/1ps
`default_nettype none
module tmr_capture_compare (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_input_a,
   input wire logic trigger_input_b,
   output logic timer_output_pin,
   output logic irq_channel_a,
   output logic irq_channel_b
);
   typedef struct packed {
      logic [7:0] mode_ctrl;
      logic [7:0] capture_compare_ctrl_reg;
      logic [3:0] output_control_reg;
      logic [7:0] prescaler_mode_reg;
      logic [15:0] capture_compare_a;
      logic [15:0] capture_compare_b;
      logic [15:0] count_register;
      logic overflow_flag;
      logic ovf_window;
      logic ever_ran;
      logic pcap_a;
      logic pcap_a_irq;
      logic pcap_b;
      logic ipend_a;
      logic ipend_b;
      logic os_armed;
      logic pin;
      logic irq_a;
      logic irq_b;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } tmr_core_st_t;
   tmr_core_st_t st_ff, nxt_st;

   tmr_tick_if tick ();
   logic [1:0] edge_rise;
   logic [1:0] edge_fall;
   logic [1:0] pins;
   logic [1:0] samples;
   tmr_pkg::tmr_mode_t mode;
   logic run, va, vb, rev_a, cp, match_a, match_b, ovf, wr, setup;
   logic cap_a_en, cap_b_en, rev_sel, os_ok, os_trig, sw_trig, clr_ovf;
   logic cnt_clk_is_a;

   // ---------------------------------------------------------------
   // count clock and input filters
   // ---------------------------------------------------------------
   assign cnt_clk_is_a = (st_ff.prescaler_mode_reg[1:0] ==
      tmr_pkg::TMR_CK_TRIG_A);
   assign tick.sel = st_ff.prescaler_mode_reg[1:0];
   assign pins = {trigger_input_b, trigger_input_a};
   // input a as count clock is filtered at pclk rate
   assign samples = {tick.cnt_rise, cnt_clk_is_a | tick.cnt_rise};

   tmr_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_flt
         tmr_edge_filter u_flt (
            .pclk(pclk),
            .presetn(presetn),
            .sample(samples[gi]),
            .track(run | st_ff.ever_ran),
            .report(run),
            .din(pins[gi]),
            .rise(edge_rise[gi]),
            .fall(edge_fall[gi])
         );
      end
   endgenerate

   function automatic logic valid_edge(input logic [1:0] es,
      input logic r, input logic f);
      case (tmr_pkg::tmr_edge_t'(es))
         tmr_pkg::TMR_ES_FALL: valid_edge = f;
         tmr_pkg::TMR_ES_RISE: valid_edge = r;
         tmr_pkg::TMR_ES_BOTH: valid_edge = r | f;
         default: valid_edge = 1'b0;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign mode = tmr_pkg::tmr_mode_t'(
      st_ff.mode_ctrl[tmr_pkg::MODE_LO +: 2]);
   assign run = (mode != tmr_pkg::TMR_STOP);
   assign va = valid_edge(
      st_ff.prescaler_mode_reg[tmr_pkg::PR_ES_A_LO +: 2],
      edge_rise[0], edge_fall[0]);
   assign vb = valid_edge(
      st_ff.prescaler_mode_reg[tmr_pkg::PR_ES_B_LO +: 2],
      edge_rise[1], edge_fall[1]);
   assign rev_a = valid_edge(
      st_ff.prescaler_mode_reg[tmr_pkg::PR_ES_A_LO +: 2],
      edge_fall[0], edge_rise[0]);
   assign cap_a_en = st_ff.capture_compare_ctrl_reg[tmr_pkg::CC_A_CAPTURE];
   assign cap_b_en = st_ff.capture_compare_ctrl_reg[tmr_pkg::CC_B_CAPTURE];
   assign rev_sel = st_ff.capture_compare_ctrl_reg[tmr_pkg::CC_REV_PHASE];
   assign cp = run && (cnt_clk_is_a ? va : tick.cnt_rise);
   assign match_a = cp && !cap_a_en &&
      (st_ff.count_register == st_ff.capture_compare_a);
   assign match_b = cp && !cap_b_en &&
      (st_ff.count_register == st_ff.capture_compare_b);
   // true wrap and an ffff match-clear both leave ffff for zero
   assign ovf = cp && (st_ff.count_register == tmr_pkg::COUNT_MAX);
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && st_ff.ready;
   assign sw_trig = wr && (paddr == tmr_pkg::OFS_OUT_CTRL) &&
      pwdata[tmr_pkg::OC_TRIGGER];
   assign os_ok = (mode == tmr_pkg::TMR_FREE) ||
      (mode == tmr_pkg::TMR_CLR_EDGE);
   assign os_trig = os_ok &&
      st_ff.output_control_reg[tmr_pkg::OC_ONESHOT] &&
      (sw_trig || ((mode == tmr_pkg::TMR_CLR_EDGE) && va));
   assign clr_ovf = wr && (paddr == tmr_pkg::OFS_STATUS) &&
      pwdata[tmr_pkg::ST_OVF];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.irq_a = 1'b0;
      nxt_st.irq_b = 1'b0;
      nxt_st.ready = setup;
      nxt_st.slverr = 1'b0;
      // register writes, at the access edge only
      if (wr) begin
         case (paddr)
            tmr_pkg::OFS_MODE_CTRL: nxt_st.mode_ctrl = pwdata[7:0];
            tmr_pkg::OFS_CC_CTRL:
               nxt_st.capture_compare_ctrl_reg = pwdata[7:0];
            tmr_pkg::OFS_OUT_CTRL: nxt_st.output_control_reg = pwdata[3:0];
            tmr_pkg::OFS_PRESCALER: nxt_st.prescaler_mode_reg = pwdata[7:0];
            tmr_pkg::OFS_CC_A: nxt_st.capture_compare_a = pwdata[15:0];
            tmr_pkg::OFS_CC_B: nxt_st.capture_compare_b = pwdata[15:0];
            default: ;
         endcase
      end
      // clear refused while the counter still sits at zero
      if (clr_ovf && !st_ff.ovf_window) begin
         nxt_st.overflow_flag = 1'b0;
      end
      if (!run) begin
         // compare contents left as they are, not guaranteed
         nxt_st.count_register = tmr_pkg::COUNT_ZERO;
         nxt_st.ovf_window = 1'b0;
         nxt_st.pcap_a = 1'b0;
         nxt_st.pcap_a_irq = 1'b0;
         nxt_st.pcap_b = 1'b0;
         nxt_st.ipend_a = 1'b0;
         nxt_st.ipend_b = 1'b0;
         nxt_st.os_armed = 1'b0;
      end else begin
         nxt_st.ever_ran = 1'b1;
         if (cp) begin
            if (mode == tmr_pkg::TMR_CLR_MATCH && match_a) begin
               nxt_st.count_register = tmr_pkg::COUNT_ZERO;
            end else begin
               nxt_st.count_register = st_ff.count_register + 16'h0001;
            end
            if (st_ff.count_register == tmr_pkg::COUNT_ZERO) begin
               nxt_st.ovf_window = 1'b0;
            end
         end
         if (mode == tmr_pkg::TMR_CLR_EDGE && va) begin
            nxt_st.count_register = tmr_pkg::COUNT_ZERO;
         end
         // interrupts queued by a capture go out on a rising phase
         if (tick.cnt_rise) begin
            nxt_st.irq_a = st_ff.ipend_a;
            nxt_st.irq_b = st_ff.ipend_b;
            nxt_st.ipend_a = 1'b0;
            nxt_st.ipend_b = 1'b0;
         end
         // captures latch on a falling phase, even mid read
         if (tick.cnt_fall) begin
            if (st_ff.pcap_a) begin
               nxt_st.capture_compare_a = st_ff.count_register;
               nxt_st.ipend_a = nxt_st.ipend_a | st_ff.pcap_a_irq;
               nxt_st.pcap_a = 1'b0;
            end
            if (st_ff.pcap_b) begin
               nxt_st.capture_compare_b = st_ff.count_register;
               nxt_st.ipend_b = 1'b1;
               nxt_st.pcap_b = 1'b0;
            end
         end
         if (cap_a_en && rev_sel) begin
            // reverse phase capture stays silent; b acts as an
            // external interrupt for channel a
            if (rev_a) begin
               nxt_st.pcap_a = 1'b1;
               nxt_st.pcap_a_irq = 1'b0;
            end
            if (vb) begin
               nxt_st.ipend_a = 1'b1;
            end
         end else if (cap_a_en && vb) begin
            nxt_st.pcap_a = 1'b1;
            nxt_st.pcap_a_irq = 1'b1;
         end
         if (cap_b_en && va) begin
            nxt_st.pcap_b = 1'b1;
         end
         nxt_st.irq_a = nxt_st.irq_a | match_a;
         nxt_st.irq_b = nxt_st.irq_b | match_b;
         // output pin: toggle on matches or one-shot pulse
         if (st_ff.output_control_reg[tmr_pkg::OC_ONESHOT]) begin
            if (os_trig) begin
               nxt_st.os_armed = 1'b1;
            end
            if (st_ff.os_armed && match_b) begin
               nxt_st.pin = 1'b1;
            end
            if (st_ff.os_armed && match_a) begin
               nxt_st.pin = 1'b0;
               nxt_st.os_armed = os_trig;
            end
            if (!os_ok) begin
               nxt_st.os_armed = 1'b0;
               nxt_st.pin = 1'b0;
            end
         end else begin
            nxt_st.os_armed = 1'b0;
            if ((match_a && st_ff.output_control_reg[tmr_pkg::OC_INV_A])
               ^ (match_b && st_ff.output_control_reg[tmr_pkg::OC_INV_B]))
               begin
               nxt_st.pin = !st_ff.pin;
            end
         end
      end
      if (!st_ff.output_control_reg[tmr_pkg::OC_ENABLE]) begin
         nxt_st.pin = 1'b0;
      end
      // set wins over a software clear in the same cycle
      if (ovf) begin
         nxt_st.overflow_flag = 1'b1;
         nxt_st.ovf_window = 1'b1;
      end
      // read data is taken in the setup cycle, pready follows
      if (setup) begin
         nxt_st.rdata = 32'h0000_0000;
         case (paddr)
            tmr_pkg::OFS_MODE_CTRL: nxt_st.rdata[7:0] = st_ff.mode_ctrl;
            tmr_pkg::OFS_CC_CTRL:
               nxt_st.rdata[7:0] = st_ff.capture_compare_ctrl_reg;
            tmr_pkg::OFS_OUT_CTRL:
               nxt_st.rdata[3:0] = st_ff.output_control_reg;
            tmr_pkg::OFS_PRESCALER:
               nxt_st.rdata[7:0] = st_ff.prescaler_mode_reg;
            tmr_pkg::OFS_CC_A: nxt_st.rdata[15:0] = st_ff.capture_compare_a;
            tmr_pkg::OFS_CC_B: nxt_st.rdata[15:0] = st_ff.capture_compare_b;
            tmr_pkg::OFS_COUNT: nxt_st.rdata[15:0] = st_ff.count_register;
            tmr_pkg::OFS_STATUS: nxt_st.rdata[0] = st_ff.overflow_flag;
            default: nxt_st.slverr = 1'b1;
         endcase
      end else if (!(psel && penable && !st_ff.ready)) begin
         nxt_st.slverr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.rdata;
   assign pready = st_ff.ready;
   assign pslverr = st_ff.slverr;
   assign timer_output_pin = st_ff.pin;
   assign irq_channel_a = st_ff.irq_a;
   assign irq_channel_b = st_ff.irq_b;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   stop_no_irq_a: assert property (!run |=> !irq_channel_a
      && !irq_channel_b) else $error("interrupt while stopped");
   ovf_set_a: assert property (ovf |=> st_ff.overflow_flag)
      else $error("overflow flag not set");
   ovf_hold_a: assert property (st_ff.ovf_window |->
      st_ff.overflow_flag) else $error("overflow cleared too early");
   cap_latch_a: assert property (run && st_ff.pcap_a && tick.cnt_fall
      |=> st_ff.capture_compare_a == $past(st_ff.count_register))
      else $error("capture a not latched on fall");
   irq_rise_a: assert property (run && st_ff.ipend_a && tick.cnt_rise
      |=> irq_channel_a) else $error("capture interrupt missing");
   rev_silent_a: assert property (st_ff.pcap_a && !st_ff.pcap_a_irq
      |-> rev_sel) else $error("silent capture outside reverse phase");
   oneshot_mode_a: assert property (mode == tmr_pkg::TMR_CLR_MATCH
      |=> !st_ff.os_armed) else $error("one-shot armed in match clear");
   cover_ovf_c: cover property (ovf ##1 clr_ovf);
   cover_cap_c: cover property (st_ff.pcap_b ##[1:40] irq_channel_b);
   cover_os_c: cover property (st_ff.os_armed ##[1:300] timer_output_pin);
endmodule // tmr_capture_compare
`default_nettype wire

// ### src/tmr_pkg.sv
// constants shared by the 16-bit timer capture/compare block
package tmr_pkg;
   // -------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
   localparam logic [7:0] OFS_CC_CTRL = 8'h04;
   localparam logic [7:0] OFS_OUT_CTRL = 8'h08;
   localparam logic [7:0] OFS_PRESCALER = 8'h0c;
   localparam logic [7:0] OFS_CC_A = 8'h10;
   localparam logic [7:0] OFS_CC_B = 8'h14;
   localparam logic [7:0] OFS_COUNT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int MODE_LO = 2;
   localparam int CC_A_CAPTURE = 0;
   localparam int CC_REV_PHASE = 1;
   localparam int CC_B_CAPTURE = 2;
   localparam int OC_ENABLE = 0;
   localparam int OC_INV_A = 1;
   localparam int OC_INV_B = 2;
   localparam int OC_ONESHOT = 3;
   localparam int OC_TRIGGER = 4;
   localparam int PR_ES_A_LO = 4;
   localparam int PR_ES_B_LO = 6;
   localparam int ST_OVF = 0;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [15:0] RST_CC = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [3:0] DIV4_LAST = 4'h3;
   localparam logic [3:0] DIV16_LAST = 4'hf;
   localparam logic [3:0] DIV_ZERO = 4'h0;
   // -------------------------------------------------------------
   // enumerations
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      TMR_STOP = 2'b00,
      TMR_CLR_EDGE = 2'b01,
      TMR_FREE = 2'b10,
      TMR_CLR_MATCH = 2'b11
   } tmr_mode_t;
   typedef enum logic [1:0] {
      TMR_ES_FALL = 2'b00,
      TMR_ES_RISE = 2'b01,
      TMR_ES_NONE = 2'b10,
      TMR_ES_BOTH = 2'b11
   } tmr_edge_t;
   typedef enum logic [1:0] {
      TMR_CK_DIV1 = 2'b00,
      TMR_CK_DIV4 = 2'b01,
      TMR_CK_DIV16 = 2'b10,
      TMR_CK_TRIG_A = 2'b11
   } tmr_clk_t;
endpackage

// ### src/tmr_tick_if.sv
// count clock phase strobes between prescaler and timer core
`timescale 1ns/1ps
`default_nettype none
interface tmr_tick_if;
   logic [1:0] sel;
   logic cnt_rise;
   logic cnt_fall;
   modport src (input sel, output cnt_rise, output cnt_fall);
   modport dst (output sel, input cnt_rise, input cnt_fall);
endinterface
`default_nettype wire

// ### src/tmr_prescaler.sv
// free-running prescaler giving rising and falling count clock phases
`timescale 1ns/1ps
`default_nettype none
module tmr_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   tmr_tick_if.src tick
);
   typedef struct packed {
      logic [3:0] div;
      logic rise;
      logic fall;
   } tmr_pre_st_t;
   tmr_pre_st_t st_ff, nxt_st;
   logic [3:0] last;

   // ---------------------------------------------------------------
   // divider
   // ---------------------------------------------------------------
   // never restarted by a timer start, so the first count pulse
   // lands anywhere within one count period
   always_comb begin
      nxt_st = st_ff;
      case (tmr_pkg::tmr_clk_t'(tick.sel))
         tmr_pkg::TMR_CK_DIV4: last = tmr_pkg::DIV4_LAST;
         tmr_pkg::TMR_CK_DIV16: last = tmr_pkg::DIV16_LAST;
         default: last = tmr_pkg::DIV_ZERO;
      endcase
      if (st_ff.div >= last) begin
         nxt_st.div = tmr_pkg::DIV_ZERO;
      end else begin
         nxt_st.div = st_ff.div + 4'h1;
      end
      nxt_st.rise = (nxt_st.div == tmr_pkg::DIV_ZERO);
      nxt_st.fall = (nxt_st.div == (last >> 1)) || (last == 4'h0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick.cnt_rise = st_ff.rise;
   assign tick.cnt_fall = st_ff.fall;
endmodule // tmr_prescaler
`default_nettype wire

// ### src/tmr_edge_filter.sv
// two-sample noise filter and edge detector for one trigger input
`timescale 1ns/1ps
`default_nettype none
module tmr_edge_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample,
   input wire logic track,
   input wire logic report,
   input wire logic din,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic stable;
      logic rise;
      logic fall;
   } tmr_flt_st_t;
   tmr_flt_st_t st_ff, nxt_st;
   logic change;

   // ---------------------------------------------------------------
   // filter
   // ---------------------------------------------------------------
   // stable starts low, so a pin already high at the first enable
   // reads as a rising edge; later stops keep tracking the level
   // quietly so a restart sees no false edge
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rise = 1'b0;
      nxt_st.fall = 1'b0;
      change = (st_ff.s1 == st_ff.s2) && (st_ff.s1 != st_ff.stable);
      if (sample) begin
         nxt_st.s1 = din;
         nxt_st.s2 = st_ff.s1;
      end
      if (track && change) begin
         nxt_st.stable = st_ff.s1;
         nxt_st.rise = report && st_ff.s1;
         nxt_st.fall = report && !st_ff.s1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rise = st_ff.rise;
   assign fall = st_ff.fall;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   two_samples_a: assert property (rise |-> $past(st_ff.s1)
      && $past(st_ff.s2)) else $error("edge without two samples");
   quiet_stop_a: assert property (!report |=> !rise && !fall)
      else $error("edge reported while stopped");
endmodule // tmr_edge_filter
`default_nettype wire

// ### sim/tmr_trig_src.sv
// trigger source model driving both timer trigger inputs
`timescale 1ns/1ps
`default_nettype none
module tmr_trig_src (
   input wire logic pclk,
   input wire logic fire_a,
   input wire logic fire_b,
   input wire logic [7:0] width,
   output logic trig_a,
   output logic trig_b
);
   int left_a = 0;
   int left_b = 0;
   // -------------------------------------------------------------
   // pulse generators, width set by the bench
   // -------------------------------------------------------------
   // a request during an active level is dropped, never restarted
   always @(posedge pclk) begin
      if (fire_a && left_a == 0) begin
         left_a <= int'(width);
      end else if (left_a > 0) begin
         left_a <= left_a - 1;
      end
      if (fire_b && left_b == 0) begin
         left_b <= int'(width);
      end else if (left_b > 0) begin
         left_b <= left_b - 1;
      end
   end
   assign trig_a = (left_a > 0);
   assign trig_b = (left_b > 0);
endmodule // tmr_trig_src
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the timer capture/compare block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, trig_a, trig_b, pin, irq_a, irq_b, e;
   logic fire_a = 1'b0;
   logic fire_b = 1'b0;
   logic [7:0] width = 8'h00;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0, cnt_a = 0, cnt_b = 0, last_a = 0, prev_a = 0;
   int last_b = 0, pin_cnt = 0, n, t0, c0;

   tmr_capture_compare i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger_input_a(trig_a),
      .trigger_input_b(trig_b), .timer_output_pin(pin),
      .irq_channel_a(irq_a), .irq_channel_b(irq_b));
   tmr_trig_src i_src (
      .pclk(pclk), .fire_a(fire_a), .fire_b(fire_b), .width(width),
      .trig_a(trig_a), .trig_b(trig_b));

   always #2.5 pclk = ~pclk;

   // -------------------------------------------------------------
   // event recorder
   // -------------------------------------------------------------
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (irq_a === 1'b1) begin
         cnt_a <= cnt_a + 1;
         prev_a <= last_a;
         last_a <= cyc;
      end
      if (irq_b === 1'b1) begin
         cnt_b <= cnt_b + 1;
         last_b <= cyc;
      end
      if (pin === 1'b1) begin
         pin_cnt <= pin_cnt + 1;
      end
   end

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask

   // starts one edge late so a release never meets a new setup
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      check({31'h0, pready}, 32'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic pulse(input logic b, input logic [7:0] w);
      @(posedge pclk);
      width <= w;
      if (b) begin
         fire_b <= 1'b1;
      end else begin
         fire_a <= 1'b1;
      end
      @(posedge pclk);
      fire_a <= 1'b0;
      fire_b <= 1'b0;
   endtask

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      void'($urandom(33));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 32; a += 4) begin
         rd(8'(a));
         check(q, 32'h0);
      end
      rd(8'h20);
      check({31'h0, e}, 32'h1);
      $display("test reset done");
      // input a already high at the first start after reset
      pulse(1'b0, 8'd200);
      wr(tmr_pkg::OFS_PRESCALER, 32'h50);
      wr(tmr_pkg::OFS_CC_CTRL, 32'h4);
      c0 = cnt_b;
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h8);
      repeat (15) @(posedge pclk);
      check(32'(cnt_b - c0), 32'h1);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      c0 = cnt_b;
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h8);
      repeat (15) @(posedge pclk);
      check(32'(cnt_b - c0), 32'h0);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      repeat (200) @(posedge pclk);
      c0 = cnt_b;
      pulse(1'b0, 8'd8);
      pulse(1'b1, 8'd8);
      repeat (20) @(posedge pclk);
      check(32'(cnt_b - c0), 32'h0);
      $display("test edges at start done");
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h8);
      c0 = cnt_b;
      pulse(1'b0, 8'd1);
      repeat (20) @(posedge pclk);
      check(32'(cnt_b - c0), 32'h0);
      t0 = cyc;
      pulse(1'b0, 8'd6);
      repeat (20) @(posedge pclk);
      check(32'(cnt_b - c0), 32'h1);
      check(32'(last_b - t0 >= 4 && last_b - t0 <= 12), 32'h1);
      $display("test capture done");
      // edge-clear mode with the timer output left unused
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h4);
      repeat (30) @(posedge pclk);
      pulse(1'b0, 8'd6);
      repeat (10) @(posedge pclk);
      rd(tmr_pkg::OFS_COUNT);
      check(32'(q > 32'd2 && q < 32'd13), 32'h1);
      $display("test edge clear done");
      // compare match period with a random compare value
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      n = 5 + int'($urandom % 20);
      wr(tmr_pkg::OFS_CC_CTRL, 32'h0);
      wr(tmr_pkg::OFS_CC_A, 32'(n));
      wr(tmr_pkg::OFS_CC_B, 32'h2);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'hc);
      repeat (3 * n + 30) @(posedge pclk);
      check(32'(last_a - prev_a), 32'(n + 1));
      rd(tmr_pkg::OFS_STATUS);
      check(q, 32'h0);
      c0 = pin_cnt;
      // one-shot mode first, so the trigger is not lost in the same write
      wr(tmr_pkg::OFS_OUT_CTRL, 32'h9);
      wr(tmr_pkg::OFS_OUT_CTRL, 32'h19);
      repeat (60) @(posedge pclk);
      check(32'(pin_cnt - c0), 32'h0);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      wr(tmr_pkg::OFS_OUT_CTRL, 32'h0);
      wr(tmr_pkg::OFS_CC_A, 32'd20);
      wr(tmr_pkg::OFS_CC_B, 32'd10);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h8);
      c0 = pin_cnt;
      wr(tmr_pkg::OFS_OUT_CTRL, 32'h9);
      wr(tmr_pkg::OFS_OUT_CTRL, 32'h19);
      repeat (60) @(posedge pclk);
      check(32'(pin_cnt - c0), 32'd10);
      $display("test match and one-shot done");
      // divided count clock, then counting valid edges of input a
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      wr(tmr_pkg::OFS_CC_CTRL, 32'h0);
      wr(tmr_pkg::OFS_PRESCALER, 32'h51);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h8);
      repeat (40) @(posedge pclk);
      rd(tmr_pkg::OFS_COUNT);
      check(32'(q >= 32'd8 && q <= 32'd12), 32'h1);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      wr(tmr_pkg::OFS_PRESCALER, 32'h53);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h8);
      repeat (3) begin
         pulse(1'b0, 8'd4);
         repeat (8) @(posedge pclk);
      end
      rd(tmr_pkg::OFS_COUNT);
      check(q, 32'h3);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      wr(tmr_pkg::OFS_PRESCALER, 32'h50);
      $display("test count clocks done");
      wr(tmr_pkg::OFS_MODE_CTRL, 32'h0);
      wr(tmr_pkg::OFS_OUT_CTRL, 32'h0);
      wr(tmr_pkg::OFS_CC_A, 32'hffff);
      wr(tmr_pkg::OFS_CC_B, 32'h1);
      wr(tmr_pkg::OFS_MODE_CTRL, 32'hc);
      c0 = cnt_a;
      n = 0;
      while (cnt_a == c0 && n < 70000) begin
         @(posedge pclk);
         n++;
      end
      rd(tmr_pkg::OFS_STATUS);
      check(q, 32'h1);
      wr(tmr_pkg::OFS_STATUS, 32'h1);
      rd(tmr_pkg::OFS_STATUS);
      check(q, 32'h0);
      $display("test overflow done");
      end_sim;
   end

   // whole run needs about 66000 cycles
   initial begin
      repeat (90000) @(posedge pclk);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
